// ### hdl/bcdrtc_pkg.sv
// Constants for the BCD calendar clock with retained user registers.
// Assumes one 250 MHz system clock; the RTC pulse is divided from it.
package bcdrtc_pkg;
  // Clock rates and the RTC pulse divider
  localparam int SYS_HZ = 250_000_000;
  localparam int RTCCLK_HZ = 32768;
  localparam int RTC_DIV = SYS_HZ / RTCCLK_HZ;
  localparam int PRESC_W = 16;
  localparam int SUB_W = 15;
  localparam int CALWIN_W = 20;
  // Register byte offsets
  localparam int ADDR_W = 7;
  localparam logic [6:0] A_TIME = 7'h00;
  localparam logic [6:0] A_DATE = 7'h04;
  localparam logic [6:0] A_CTRL = 7'h08;
  localparam logic [6:0] A_SUB = 7'h0C;
  localparam logic [6:0] A_SHIFT = 7'h10;
  localparam logic [6:0] A_CAL = 7'h14;
  localparam logic [6:0] A_ALRA = 7'h18;
  localparam logic [6:0] A_ALRB = 7'h1C;
  localparam logic [6:0] A_TSTIME = 7'h20;
  localparam logic [6:0] A_TSDATE = 7'h24;
  localparam logic [6:0] A_STS = 7'h28;
  localparam logic [6:0] A_CLR = 7'h2C;
  localparam logic [6:0] A_IEN = 7'h30;
  localparam int BKP_SEL = 6;
  localparam int N_BKP = 16;
  // Control bits
  localparam int CTRL_W = 12;
  localparam int C_FMT12 = 0;
  localparam int C_REFEN = 1;
  localparam int C_REF60 = 2;
  localparam int C_TAMPTS = 3;
  localparam int C_ALRA = 4;
  localparam int C_ALRB = 5;
  localparam int C_TAMPEN = 6;
  localparam int C_TSEN = 9;
  localparam int C_FLT = 10;
  // Status, clear and enable bits
  localparam int STS_W = 6;
  localparam int ST_ALRA = 0;
  localparam int ST_ALRB = 1;
  localparam int ST_TAMP = 2;
  localparam int ST_TS = 5;
  localparam int N_TAMP = 3;
  // Calibration field
  localparam int CAL_MAG_W = 9;
  localparam int CAL_PLUS = 15;
  // Reference edges per second, minus one
  localparam logic [5:0] REF50_LAST = 6'h31;
  localparam logic [5:0] REF60_LAST = 6'h3B;
  // Calendar reset values
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_MON = 8'h01;
  localparam logic [2:0] RST_WDAY = 3'h1;
endpackage

// ### hdl/bcdrtc_top.sv
// BCD calendar clock with alarms, tamper, timestamp and retained registers.
// Assumes a plain register port in the system clock domain and
// tamper, timestamp and reference pins asynchronous to that clock.
// What this block does
// R1: Sixteen retained 32-bit user registers
// R2: User registers survive every reset
// R3: BCD calendar from subseconds to years
// R4: Hours in 12 or 24 hour form
// R5: Mains reference disciplines seconds when enabled
// R6: Month length with leap February
// R7: Two alarms able to wake chip
// R8: Shift count by 1 to 32767 pulses
// R9: Digital calibration adds or removes pulses
// R10: Three tamper inputs with programmable filter
// R11: Tamper event can wake chip
// R12: Timestamp captures calendar on pin or tamper
// R13: Timestamp event can wake chip
// R14: Alarm flag sticks until software clears
module bcdrtc_top #(
  parameter int RTC_DIV_CYC = bcdrtc_pkg::RTC_DIV
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Register port
  input wire logic [bcdrtc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Event pins
  input wire logic [bcdrtc_pkg::N_TAMP-1:0] i_tamper,
  input wire logic i_tstamp,
  input wire logic i_refclk,
  // Interrupt and wake
  output logic o_irq,
  output logic o_wakeup
);
  import bcdrtc_pkg::*;

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic [SUB_W-1:0] sub;
    logic [CALWIN_W-1:0] calwin;
    logic [5:0] refcnt;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic pm;
    logic [2:0] wday;
    logic [7:0] date;
    logic [7:0] mon;
    logic [7:0] year;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] cal;
    logic [31:0] alra;
    logic [31:0] alrb;
    logic [31:0] tstime;
    logic [31:0] tsdate;
    logic [STS_W-1:0] sts;
    logic [STS_W-1:0] ien;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] prv;
    logic [N_TAMP-1:0][3:0] fcnt;
    logic [31:0] rdata;
    logic irq;
    logic wake;
  } bcdrtc_state_t;

  localparam bcdrtc_state_t ST_RST = '{date: RST_DATE, mon: RST_MON,
                                       wday: RST_WDAY, default: '0};

  bcdrtc_state_t q;
  bcdrtc_state_t n;
  logic [31:0] bkp [N_BKP];
  logic rtc_pls;
  logic cal_act;
  logic [1:0] inc;
  logic [16:0] sum;
  logic tick;
  logic day_end;
  logic ts_trig;
  logic [3:0] lim;
  logic [STS_W-1:0] ev;
  logic [STS_W-1:0] clr;
  logic [31:0] time_w;
  logic [31:0] date_w;

  // BCD step with wrap from top back to bottom
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                         input logic [7:0] bot);
    if (v == top) begin
      bcd_inc = bot;
    end else if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last date of the month; BCD year divisible by four is a leap year
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
           (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  // Alarm compare; a set mask bit makes that field a don't care
  function automatic logic alr_hit(input logic [31:0] a, input bcdrtc_state_t c);
    alr_hit = (a[7] || a[6:0] == c.sec[6:0]) &&
              (a[15] || a[14:8] == c.min[6:0]) &&
              (a[23] || a[22:16] == {c.pm, c.hour[5:0]}) &&
              (a[31] || a[29:24] == c.date[5:0]);
  endfunction

  // Next-state logic for the whole block except the retained bank
  always_comb begin
    n = q;
    ev = '0;
    tick = 1'b0;
    day_end = 1'b0;
    // Two-flop synchronisers, then a third stage for edge detection
    n.s1 = {i_refclk, i_tstamp, i_tamper};
    n.s2 = q.s1;
    n.prv = q.s2;
    // RTC pulse divider from the system clock
    rtc_pls = (q.presc == PRESC_W'(RTC_DIV_CYC - 1));
    n.presc = rtc_pls ? '0 : q.presc + 16'h0001;
    // Over a 2^20 pulse window the first calm pulses are doubled or dropped
    cal_act = rtc_pls && (q.calwin < CALWIN_W'(q.cal[CAL_MAG_W-1:0])); // R9
    if (rtc_pls) begin
      n.calwin = q.calwin + 20'h00001;
    end
    inc = !rtc_pls ? 2'h0 : !cal_act ? 2'h1 : q.cal[CAL_PLUS] ? 2'h2 : 2'h0; // R9
    // A shift write advances the subsecond count at once
    sum = {2'h0, q.sub} + 17'(inc) +
          ((i_wr && i_addr == A_SHIFT) ? {2'h0, i_wdata[SUB_W-1:0]} : 17'h00000); // R8
    n.sub = sum[SUB_W-1:0];
    if (!q.ctrl[C_REFEN]) begin
      tick = |sum[16:15];
    end else if (q.s2[4] && !q.prv[4]) begin
      // Reference edges set the second and realign the subseconds
      if (q.refcnt == (q.ctrl[C_REF60] ? REF60_LAST : REF50_LAST)) begin
        n.refcnt = '0;
        n.sub = '0;
        tick = 1'b1; // R5
      end else begin
        n.refcnt = q.refcnt + 6'h01;
      end
    end
    // Calendar carry chain
    if (tick) begin
      n.sec = bcd_inc(q.sec, 8'h59, 8'h00); // R3
      if (q.sec == 8'h59) begin
        n.min = bcd_inc(q.min, 8'h59, 8'h00);
        if (q.min == 8'h59) begin
          if (q.ctrl[C_FMT12]) begin
            // 12-hour form runs 12, 01 .. 11; the AM/PM bit flips at 11 to 12
            if (q.hour == 8'h11) begin
              n.hour = 8'h12; // R4
              n.pm = ~q.pm;
              day_end = q.pm;
            end else begin
              n.hour = bcd_inc(q.hour, 8'h12, 8'h01); // R4
            end
          end else begin
            n.hour = bcd_inc(q.hour, 8'h23, 8'h00); // R4
            day_end = (q.hour == 8'h23);
          end
        end
      end
    end
    if (day_end) begin
      n.wday = (q.wday == 3'h7) ? 3'h1 : q.wday + 3'h1;
      if (q.date == last_day(q.mon, q.year)) begin
        n.date = 8'h01; // R6
        n.mon = bcd_inc(q.mon, 8'h12, 8'h01);
        if (q.mon == 8'h12) begin
          n.year = bcd_inc(q.year, 8'h99, 8'h00);
        end
      end else begin
        n.date = bcd_inc(q.date, 8'h31, 8'h01); // R6
      end
    end
    // Alarms look at the calendar value just entered
    ev[ST_ALRA] = tick && q.ctrl[C_ALRA] && alr_hit(q.alra, n); // R7
    ev[ST_ALRB] = tick && q.ctrl[C_ALRB] && alr_hit(q.alrb, n); // R7
    // Tamper filter: input must stay high for lim RTC pulses
    lim = 4'(1 << q.ctrl[C_FLT+:2]);
    for (int i = 0; i < N_TAMP; i++) begin
      if (!q.s2[i]) begin
        n.fcnt[i] = '0;
      end else if (rtc_pls && q.fcnt[i] != lim) begin
        n.fcnt[i] = q.fcnt[i] + 4'h1; // R10
        ev[ST_TAMP+i] = (q.fcnt[i] == lim - 4'h1) && q.ctrl[C_TAMPEN+i]; // R10
      end
    end
    // Timestamp on pin rising edge, or on tamper when selected
    time_w = {9'h000, q.pm, q.hour[5:0], 1'b0, q.min[6:0], 1'b0, q.sec[6:0]};
    date_w = {8'h00, q.year, q.wday, q.mon[4:0], 2'h0, q.date[5:0]};
    ts_trig = (q.s2[3] && !q.prv[3] && q.ctrl[C_TSEN]) ||
              (q.ctrl[C_TAMPTS] && |ev[ST_TAMP+:N_TAMP]);
    if (ts_trig) begin
      n.tstime = time_w; // R12
      n.tsdate = date_w; // R12
      ev[ST_TS] = 1'b1;
    end
    // Register writes; a calendar write wins over the carry
    if (i_wr) begin
      case (i_addr)
        A_TIME: begin
          n.sec = {1'b0, i_wdata[6:0]};
          n.min = {1'b0, i_wdata[14:8]};
          n.hour = {2'h0, i_wdata[21:16]};
          n.pm = i_wdata[22];
          n.sub = '0;
        end
        A_DATE: begin
          n.date = {2'h0, i_wdata[5:0]};
          n.mon = {3'h0, i_wdata[12:8]};
          n.wday = i_wdata[15:13];
          n.year = i_wdata[23:16];
        end
        A_CTRL: n.ctrl = i_wdata[CTRL_W-1:0];
        A_CAL: n.cal = i_wdata[15:0];
        A_ALRA: n.alra = i_wdata;
        A_ALRB: n.alrb = i_wdata;
        A_IEN: n.ien = i_wdata[STS_W-1:0];
        default: ;
      endcase
    end
    // Sticky flags: a new event wins over a clear in the same cycle
    clr = (i_wr && i_addr == A_CLR) ? i_wdata[STS_W-1:0] : '0;
    n.sts = (q.sts & ~clr) | ev; // R14
    // Read data stands for one cycle only
    n.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        A_TIME: n.rdata = time_w;
        A_DATE: n.rdata = date_w;
        A_CTRL: n.rdata = 32'(q.ctrl);
        A_SUB: n.rdata = 32'(q.sub);
        A_CAL: n.rdata = 32'(q.cal);
        A_ALRA: n.rdata = q.alra;
        A_ALRB: n.rdata = q.alrb;
        A_TSTIME: n.rdata = q.tstime;
        A_TSDATE: n.rdata = q.tsdate;
        A_STS: n.rdata = 32'(q.sts);
        A_IEN: n.rdata = 32'(q.ien);
        default: n.rdata = i_addr[BKP_SEL] ? bkp[i_addr[5:2]] : 32'h00000000; // R1
      endcase
    end
    // Interrupt follows enabled flags; wake follows any pending flag
    n.irq = |(n.sts & n.ien);
    n.wake = |n.sts; // R7 R11 R13
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // Retained bank has no reset so contents outlive any reset
  always_ff @(posedge i_clk_sys) begin
    if (i_wr && i_addr[BKP_SEL]) begin
      bkp[i_addr[5:2]] <= i_wdata; // R1 R2
    end
  end

  // Outputs straight from flops
  assign o_rdata = q.rdata;
  assign o_irq = q.irq;
  assign o_wakeup = q.wake;
endmodule

// ### sim/bcdrtc_monitor.sv
// Checker for the register port and the interrupt and wake outputs.
// Sees only the top ports; bound from the bench top file.
module bcdrtc_monitor (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Register port
  input wire logic [bcdrtc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Event pins
  input wire logic [bcdrtc_pkg::N_TAMP-1:0] i_tamper,
  input wire logic i_tstamp,
  input wire logic i_refclk,
  // Interrupt and wake
  input wire logic o_irq,
  input wire logic o_wakeup
);
  import bcdrtc_pkg::*;
  logic clr_wr;
  logic ien_wr;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // Strobe decodes, kept out of $past so it sees plain signals
  assign clr_wr = i_wr && i_addr == A_CLR;
  assign ien_wr = i_wr && i_addr == A_IEN;
  // Bus steps
  sequence s_wr(a); i_wr && i_addr == a; endsequence
  sequence s_rd_same; i_rd && i_addr == $past(i_addr); endsequence
  // Read data stands only after a read strobe
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_unmap; i_rd && i_addr inside {7'h34, 7'h38, 7'h3C} |=> o_rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Write then read back in the next cycle
  property p_bkp_rw; i_wr && i_addr[6] ##1 s_rd_same |=> o_rdata == $past(i_wdata, 2); endproperty
  a_bkp_rw: assert property (p_bkp_rw) else $error("user word readback wrong");
  property p_ctrl_rb;
    s_wr(A_CTRL) ##1 (i_rd && i_addr == A_CTRL) |=> o_rdata == ($past(i_wdata, 2) & 32'hFFF);
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  // Interrupt follows the enables; flags drop only when cleared
  property p_ien_off; (s_wr(A_IEN) ##0 i_wdata[5:0] == 6'h0) ##1 !ien_wr |=> !o_irq; endproperty
  a_ien_off: assert property (p_ien_off) else $error("irq with all enables off");
  // Flags and both outputs settle at the edge that takes the clear, so look one step back
  property p_wake_fall; $fell(o_wakeup) |-> $past(clr_wr); endproperty
  a_wake_fall: assert property (p_wake_fall) else $error("wake fell without clear");
  property p_irq_fall; $fell(o_irq) |-> $past(clr_wr) || $past(ien_wr); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
  property p_irq_wake; o_irq |-> o_wakeup; endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq without wake");
endmodule

// ### sim/tb_bcdrtc_top.sv
// Self-checking bench for the BCD calendar clock.
// Assumes a short RTC pulse divider so second ticks come fast.
module tb_bcdrtc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bcdrtc_pkg::*;
  logic i_clk_sys, i_resetn, i_wr, i_rd, i_tstamp, i_refclk, o_irq, o_wakeup;
  logic [6:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [2:0] i_tamper;
  int n_fail, n_tests, cyc;
  // Register rows: address, write value, readback
  logic [6:0] ra [9] = '{A_CTRL, A_ALRA, A_ALRB, A_IEN, A_TSTIME, 7'h34, 7'h40, 7'h5C, 7'h7C};
  logic [31:0] rw [9] = '{32'hA5, '1, 32'h12345678, 32'hFF, '1, '1, 32'hA5A5A5A5, 1, 32'h5A5A5A5A};
  logic [31:0] rx [9] = '{32'hA5, 32'hFFFFFFFF, 32'h12345678, 32'h3F, 0, 0, 32'hA5A5A5A5, 1,
    32'h5A5A5A5A};
  // Calendar rows: control, time, date, then time and date after one tick
  logic [31:0] cc [6] = '{0, 0, 0, 0, 0, 1};
  logic [31:0] ct [6] = '{32'h235959, 32'h235959, 32'h235959, 32'h235959, 32'h235959, 32'h115959};
  logic [31:0] cd [6] = '{32'h246228, 32'h248229, 32'h236228, 32'h232430, 32'h99F231, 32'h242101};
  logic [31:0] et [6] = '{0, 0, 0, 0, 0, 32'h520000};
  logic [31:0] ed [6] = '{32'h248229, 32'h24A301, 32'h238301, 32'h234501, 32'h2101, 32'h242101};
  // Clock, 4 ns period
  always #2 i_clk_sys = ~i_clk_sys;
  bcdrtc_top #(.RTC_DIV_CYC(4)) u_dut (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tamper(i_tamper), .i_tstamp(i_tstamp),
    .i_refclk(i_refclk), .o_irq(o_irq), .o_wakeup(o_wakeup));
  // Bus tasks start just after an edge and end one ns after the next, or after the nth for idle
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys) #1;
  endtask
  task automatic idle(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_clk_sys) #1;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rc(input logic [6:0] a, input logic [31:0] e);
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    i_addr <= a;
    @(posedge i_clk_sys) #1;
    chk($sformatf("reg %h", a), e, o_rdata);
  endtask
  // Shift pushes the subsecond count to its carry
  // A full shift only carries once at least one RTC pulse has counted
  task automatic tick;
    idle(4);
    wr(A_SHIFT, 32'h7FFF);
    idle(40);
  endtask
  task automatic pulse;
    i_refclk <= 1'b1;
    idle(4);
    i_refclk <= 1'b0;
    idle(4);
  endtask
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, well above the fewer than one thousand cycles needed
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  // Main sequence
  initial begin
    {i_clk_sys, i_resetn, i_wr, i_rd, i_tstamp, i_refclk, i_tamper} = '0;
    {i_addr, i_wdata} = '0;
    idle(2);
    i_resetn <= 1'b1;
    idle(1);
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], rw[i]);
      rc(ra[i], rx[i]);
    end
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      wr(A_CTRL, cc[i]);
      wr(A_DATE, cd[i]);
      wr(A_TIME, ct[i]);
      tick();
      rc(A_TIME, et[i]);
      rc(A_DATE, ed[i]);
    end
    $display("test calendar done");
    wr(A_ALRA, 32'h80808005);
    wr(A_IEN, 32'h1);
    wr(A_CTRL, 32'h10);
    wr(A_TIME, 32'h4);
    tick();
    rc(A_STS, 32'h1);
    chk("irq", 32'h1, 32'(o_irq));
    wr(A_IEN, 32'h0);
    idle(2);
    chk("irq masked", 32'h0, 32'(o_irq));
    chk("wake", 32'h1, 32'(o_wakeup));
    wr(A_CLR, 32'h3F);
    idle(2);
    rc(A_STS, 32'h0);
    chk("wake cleared", 32'h0, 32'(o_wakeup));
    $display("test alarm done");
    wr(A_TIME, 32'h123456);
    wr(A_CTRL, 32'h48);
    i_tamper <= 3'b001;
    idle(30);
    rc(A_STS, 32'h24);
    rc(A_TSTIME, 32'h123456);
    chk("tamper wake", 32'h1, 32'(o_wakeup));
    wr(A_CLR, 32'h3F);
    wr(A_CTRL, 32'h200);
    i_tamper <= 3'b010;
    i_tstamp <= 1'b1;
    idle(10);
    rc(A_STS, 32'h20);
    $display("test tamper done");
    wr(A_CLR, 32'h3F);
    wr(A_CTRL, 32'h2);
    wr(A_TIME, 32'h0);
    repeat (49) pulse();
    rc(A_TIME, 32'h0);
    pulse();
    rc(A_TIME, 32'h1);
    $display("test reference done");
    i_resetn <= 1'b0;
    idle(2);
    i_resetn <= 1'b1;
    idle(1);
    rc(7'h40, 32'hA5A5A5A5);
    rc(A_DATE, 32'h2101);
    rc(A_STS, 32'h0);
    $display("test reset done");
    results();
  end
endmodule
bind bcdrtc_top bcdrtc_monitor u_mon (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tamper(i_tamper), .i_tstamp(i_tstamp),
  .i_refclk(i_refclk), .o_irq(o_irq), .o_wakeup(o_wakeup));
